// >>> fsp_cfg.svh
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH

// ****************************************************************
// register byte offsets on the control bus
// ****************************************************************
`define FSP_OFS_FUSE 8'h00
`define FSP_OFS_FUSE_WR 8'h04
`define FSP_OFS_FLASH_CMD 8'h08
`define FSP_OFS_STATUS 8'h0C

// ****************************************************************
// fuse word layout and reset value
// ****************************************************************
`define FSP_FUSE_RESET 32'hFFFFFFFF
`define FSP_FUSE_LOCK_HI 15
`define FSP_FUSE_FETCH_BIT 16
`define FSP_FUSE_BOOT_LO 17
`define FSP_FUSE_BOOT_HI 19
`define FSP_FUSE_SEC_LO 20
`define FSP_FUSE_SEC_HI 21
`define FSP_FUSE_UWIN_BIT 22
`define FSP_FUSE_PROT_LO 16
`define FSP_FUSE_PROT_HI 22

// ****************************************************************
// flash command register layout
// ****************************************************************
`define FSP_CMD_OP_LO 0
`define FSP_CMD_OP_HI 1
`define FSP_CMD_PAGE_LO 8
`define FSP_CMD_PAGE_HI 15

// ****************************************************************
// status register layout
// ****************************************************************
`define FSP_ST_REJECT_BIT 0
`define FSP_ST_SECURITY_BIT 1
`define FSP_ST_SSE_BIT 2
`define FSP_ST_SECURE_STATE_DEBUG_ENABLE_BIT 3
`define FSP_ST_UWIN_BIT 4
`define FSP_ST_FETCH_BIT 5
`define FSP_ST_BOOT_LO 8
`define FSP_ST_BOOT_HI 10

// ****************************************************************
// axi4-lite response codes
// ****************************************************************
`define FSP_RESP_OKAY 2'h0
`define FSP_RESP_SLVERR 2'h2

`endif

// >>> fsp_pkg.sv
package fsp_pkg;

   // ****************************************************************
   // write channel states, gray along idle -> one half -> response
   // ****************************************************************
   typedef enum logic [1:0] {
      FSP_W_IDLE = 2'h0,
      FSP_W_ADDR = 2'h1,
      FSP_W_DATA = 2'h2,
      FSP_W_RESP = 2'h3
   } fsp_wstate_t;

   // flash page operations handed to the flash controller
   typedef enum logic [1:0] {
      FSP_OP_NONE = 2'h0,
      FSP_OP_ERASE = 2'h1,
      FSP_OP_PROGRAM = 2'h2,
      FSP_OP_RSVD = 2'h3
   } fsp_op_t;

endpackage

// >>> fsp_boot_guard.sv
`timescale 1ns/1ns

// ****************************************************************
// boot area size decode and page compare
// ****************************************************************
module fsp_boot_guard
   import fsp_pkg::*;
(
   input wire logic [2:0] boot_area_size_select,
   input wire logic [7:0] page,
   output logic [8:0] boot_pages,
   output logic page_in_boot
);

   // erased value 7 guards nothing, each step down doubles the area
   always_comb
   begin
      if (boot_area_size_select == 3'h7)
      begin
         boot_pages = 9'h000; // [R7]
      end
      else
      begin
         boot_pages = 9'h001 << (3'h7 - boot_area_size_select); // [R7]
      end
   end

   // pages are counted from the bottom of the flash
   always_comb
   begin
      page_in_boot = ({1'b0, page} < boot_pages); // [R7]
   end

endmodule

// >>> fsp_fetch_guard.sv
`timescale 1ns/1ns

// ****************************************************************
// privileged fetch gate and secure field decode
// ****************************************************************
module fsp_fetch_guard
   import fsp_pkg::*;
#(
   parameter bit HAS_EXT_MEM_IF = 1'b1,
   parameter logic [31:0] EXT_MEM_BASE = 32'hD0000000,
   parameter logic [31:0] EXT_MEM_LIMIT = 32'hDFFFFFFF
)
(
   input wire logic external_fetch_block_fuse,
   input wire logic [1:0] secure_field,
   input wire logic [31:0] fetch_addr,
   input wire logic fetch_privileged,
   output logic fetch_allow,
   output logic secure_state_enable,
   output logic secure_state_debug_enable
);

   logic in_ext; // address falls in external memory window

   // the window is device specific, so it lives in parameters
   always_comb
   begin
      in_ext = (fetch_addr >= EXT_MEM_BASE) && (fetch_addr <= EXT_MEM_LIMIT);
   end

   // programmed (0) fuse blocks privileged external fetch
   always_comb
   begin
      if (!HAS_EXT_MEM_IF)
      begin
         fetch_allow = 1'b1; // [R6]
      end
      else if (in_ext && fetch_privileged && !external_fetch_block_fuse)
      begin
         fetch_allow = 1'b0; // [R2] [R3]
      end
      else
      begin
         fetch_allow = 1'b1; // [R3]
      end
   end

   // erased field leaves secure state off
   always_comb
   begin
      case (secure_field)
         2'h3:
         begin
            secure_state_enable = 1'b0; // [R10]
            secure_state_debug_enable = 1'b0;
         end
         2'h2:
         begin
            secure_state_enable = 1'b1; // [R10]
            secure_state_debug_enable = 1'b1;
         end
         default:
         begin
            secure_state_enable = 1'b1; // [R10]
            secure_state_debug_enable = 1'b0;
         end
      endcase
   end

endmodule

// >>> fsp_top.sv
`timescale 1ns/1ns

// Behaviour
// R1 - software leaves special fuse bits for their use
// R2 - fetch lock fuse blocks privileged external fetch
// R3 - fuse 1 allows, fuse 0 forbids external execution
// R4 - fetch fuse only routed, guarded under security
// R5 - fetch fuse frozen when secure; chip erase clears
// R6 - no external interface means fetch fuse ignored
// R7 - three bits select one of eight boot sizes
// R8 - boot pages refuse erase and program
// R9 - boot field frozen when secure; chip erase clears
// R10 - secure field decodes to two enable signals
// R11 - user window fuse opens bus to test port
// R12 - protected fuse writes rejected under security
module fsp_top
   import fsp_pkg::*;
#(
   parameter bit HAS_EXT_MEM_IF = 1'b1,
   parameter logic [31:0] EXT_MEM_BASE = 32'hD0000000,
   parameter logic [31:0] EXT_MEM_LIMIT = 32'hDFFFFFFF
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire logic security_bit,
   input wire logic ext_chip_erase,
   input wire logic [31:0] fetch_addr,
   input wire logic fetch_privileged,
   output logic fetch_allow,
   output logic external_fetch_block_fuse,
   output logic secure_state_enable,
   output logic secure_state_debug_enable,
   output logic user_window_enable,
   output logic flash_op_start,
   output logic [1:0] flash_op_code,
   output logic [7:0] flash_op_page,
   output logic cmd_rejected
);

`include "fsp_cfg.svh"

   // ****************************************************************
   // declarations
   // ****************************************************************
   fsp_wstate_t wstate_r; // write channel state
   fsp_wstate_t wstate_nxt; // next write channel state
   logic [7:0] waddr_r; // latched write address
   logic [31:0] wdata_r; // latched write data
   logic [3:0] wstrb_r; // latched byte strobes
   logic [1:0] bresp_r; // write response code
   logic [31:0] rdata_r; // read data flop
   logic [1:0] rresp_r; // read response code
   logic rvalid_r; // read answer pending
   logic [31:0] fuse_r; // general-purpose fuse word
   logic [31:0] fuse_nxt; // fuse word after byte merge
   logic [15:0] cmd_r; // last flash command word
   logic reject_r; // sticky reject flag
   logic do_write; // write executes this cycle
   logic fuse_wr; // fuse write command
   logic fuse_wr_bad; // fuse write touches frozen field
   logic flash_wr; // flash page command
   logic [1:0] op_in; // requested page operation
   logic [7:0] page_in; // requested page
   logic page_in_boot; // requested page is guarded
   logic flash_bad; // flash command refused
   logic reject_set; // any refusal this cycle
   logic reject_clr; // software clears flag
   logic flash_start_r; // one-cycle start pulse
   logic [1:0] flash_code_r; // accepted operation
   logic [7:0] flash_page_r; // accepted page
   logic sse_c; // decoded secure enable
   logic secure_state_debug_enable_c; // decoded secure debug enable
   logic sse_r; // registered secure enable
   logic secure_state_debug_enable_r; // registered secure debug enable
   logic [31:0] status_c; // status word

   // ****************************************************************
   // write channel: address and data taken in either order
   // ****************************************************************

   // ready only while the matching half is still missing
   always_comb
   begin
      awready = (wstate_r == FSP_W_IDLE) || (wstate_r == FSP_W_DATA);
      wready = (wstate_r == FSP_W_IDLE) || (wstate_r == FSP_W_ADDR);
      bvalid = (wstate_r == FSP_W_RESP);
      bresp = bresp_r;
   end

   // next state for the write channel
   always_comb
   begin
      wstate_nxt = wstate_r;
      case (wstate_r)
         FSP_W_IDLE:
         begin
            if (awvalid && wvalid)
            begin
               wstate_nxt = FSP_W_RESP;
            end
            else if (awvalid)
            begin
               wstate_nxt = FSP_W_ADDR;
            end
            else if (wvalid)
            begin
               wstate_nxt = FSP_W_DATA;
            end
         end
         FSP_W_ADDR:
         begin
            if (wvalid)
            begin
               wstate_nxt = FSP_W_RESP;
            end
         end
         FSP_W_DATA:
         begin
            if (awvalid)
            begin
               wstate_nxt = FSP_W_RESP;
            end
         end
         FSP_W_RESP:
         begin
            if (bready)
            begin
               wstate_nxt = FSP_W_IDLE;
            end
         end
         default:
         begin
            wstate_nxt = FSP_W_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wstate_r <= FSP_W_IDLE;
      end
      else if (ce)
      begin
         wstate_r <= wstate_nxt;
      end
   end

   // capture each half as it is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         waddr_r <= 8'h00;
         wdata_r <= 32'h00000000;
         wstrb_r <= 4'h0;
      end
      else if (ce)
      begin
         if (awvalid && awready)
         begin
            waddr_r <= awaddr;
         end
         if (wvalid && wready)
         begin
            wdata_r <= wdata;
            wstrb_r <= wstrb;
         end
      end
   end

   // ****************************************************************
   // command decode, executed in the cycle the last half arrives
   // ****************************************************************

   // the write acts on the edge that enters the response state
   always_comb
   begin
      do_write = (wstate_r != FSP_W_RESP) && (wstate_nxt == FSP_W_RESP);
   end

   // halves may arrive in the same cycle, so pick live or held
   logic [7:0] wa_c; // effective write address
   logic [31:0] wd_c; // effective write data
   logic [3:0] ws_c; // effective strobes
   always_comb
   begin
      wa_c = (wstate_r == FSP_W_ADDR) ? waddr_r : awaddr;
      wd_c = (wstate_r == FSP_W_DATA) ? wdata_r : wdata;
      ws_c = (wstate_r == FSP_W_DATA) ? wstrb_r : wstrb;
      fuse_wr = do_write && (wa_c == `FSP_OFS_FUSE_WR);
      flash_wr = do_write && (wa_c == `FSP_OFS_FLASH_CMD);
      op_in = wd_c[`FSP_CMD_OP_HI:`FSP_CMD_OP_LO];
      page_in = wd_c[`FSP_CMD_PAGE_HI:`FSP_CMD_PAGE_LO];
   end

   // byte merge: unstrobed lanes keep the current fuse value
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1)
      begin : g_lane
         always_comb
         begin
            fuse_nxt[gi*8 +: 8] = ws_c[gi] ? wd_c[gi*8 +: 8]
                                            : fuse_r[gi*8 +: 8];
         end
      end
   endgenerate

   // any change to bits 22:16 is frozen while security is set;
   // the lock bits below stay open, their use is software's affair
   always_comb
   begin
      fuse_wr_bad = fuse_wr && security_bit &&
         (fuse_nxt[`FSP_FUSE_PROT_HI:`FSP_FUSE_PROT_LO] !=
          fuse_r[`FSP_FUSE_PROT_HI:`FSP_FUSE_PROT_LO]); // [R5] [R9] [R11] [R12]
   end

   // boot pages refuse erase and program whatever the security state
   fsp_boot_guard u_boot (
      .boot_area_size_select(fuse_r[`FSP_FUSE_BOOT_HI:`FSP_FUSE_BOOT_LO]),
      .page(page_in),
      .boot_pages(),
      .page_in_boot(page_in_boot)
   );

   // reserved or empty op codes are refused as well
   always_comb
   begin
      flash_bad = flash_wr && (page_in_boot ||
         (op_in != FSP_OP_ERASE && op_in != FSP_OP_PROGRAM)); // [R8] [R9]
      reject_set = fuse_wr_bad || flash_bad; // [R12]
      reject_clr = do_write && (wa_c == `FSP_OFS_STATUS) &&
         ws_c[0] && wd_c[`FSP_ST_REJECT_BIT];
   end

   // ****************************************************************
   // fuse word
   // ****************************************************************

   // external chip erase outranks any internal command
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         fuse_r <= `FSP_FUSE_RESET;
      end
      else if (ce)
      begin
         if (ext_chip_erase)
         begin
            fuse_r <= `FSP_FUSE_RESET; // [R5] [R9]
         end
         else if (fuse_wr && !fuse_wr_bad)
         begin
            fuse_r <= fuse_nxt; // [R12]
         end
      end
   end

   // ****************************************************************
   // flash command hand-off and reject flag
   // ****************************************************************

   // start pulse lasts one cycle with op and page held after it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         flash_start_r <= 1'b0;
         flash_code_r <= FSP_OP_NONE;
         flash_page_r <= 8'h00;
         cmd_r <= 16'h0000;
      end
      else if (ce)
      begin
         flash_start_r <= flash_wr && !flash_bad; // [R8]
         if (flash_wr)
         begin
            cmd_r <= wd_c[15:0];
         end
         if (flash_wr && !flash_bad)
         begin
            flash_code_r <= op_in;
            flash_page_r <= page_in;
         end
      end
   end

   // sticky flag: a refusal in the clearing cycle still sets it
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         reject_r <= 1'b0;
      end
      else if (ce)
      begin
         if (reject_set)
         begin
            reject_r <= 1'b1; // [R12]
         end
         else if (reject_clr)
         begin
            reject_r <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // fuse routing to core and test port
   // ****************************************************************

   // fetch fuse passes straight through, no other treatment
   fsp_fetch_guard #(
      .HAS_EXT_MEM_IF(HAS_EXT_MEM_IF),
      .EXT_MEM_BASE(EXT_MEM_BASE),
      .EXT_MEM_LIMIT(EXT_MEM_LIMIT)
   ) u_fetch (
      .external_fetch_block_fuse(fuse_r[`FSP_FUSE_FETCH_BIT]), // [R4]
      .secure_field(fuse_r[`FSP_FUSE_SEC_HI:`FSP_FUSE_SEC_LO]),
      .fetch_addr(fetch_addr),
      .fetch_privileged(fetch_privileged),
      .fetch_allow(fetch_allow),
      .secure_state_enable(sse_c),
      .secure_state_debug_enable(secure_state_debug_enable_c)
   );

   // decoded enables registered for clean core inputs
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sse_r <= 1'b0;
         secure_state_debug_enable_r <= 1'b0;
      end
      else if (ce)
      begin
         sse_r <= sse_c; // [R10]
         secure_state_debug_enable_r <= secure_state_debug_enable_c;
      end
   end

   // programmed (0) user fuse opens the window to the test port
   always_comb
   begin
      external_fetch_block_fuse = fuse_r[`FSP_FUSE_FETCH_BIT]; // [R4]
      user_window_enable = !fuse_r[`FSP_FUSE_UWIN_BIT]; // [R11]
      secure_state_enable = sse_r;
      secure_state_debug_enable = secure_state_debug_enable_r;
      flash_op_start = flash_start_r;
      flash_op_code = flash_code_r;
      flash_op_page = flash_page_r;
      cmd_rejected = reject_r;
   end

   // ****************************************************************
   // read channel and responses
   // ****************************************************************

   // status word gathers live protection state
   always_comb
   begin
      status_c = 32'h00000000;
      status_c[`FSP_ST_REJECT_BIT] = reject_r;
      status_c[`FSP_ST_SECURITY_BIT] = security_bit;
      status_c[`FSP_ST_SSE_BIT] = sse_r;
      status_c[`FSP_ST_SECURE_STATE_DEBUG_ENABLE_BIT] = secure_state_debug_enable_r;
      status_c[`FSP_ST_UWIN_BIT] = !fuse_r[`FSP_FUSE_UWIN_BIT];
      status_c[`FSP_ST_FETCH_BIT] = fuse_r[`FSP_FUSE_FETCH_BIT];
      status_c[`FSP_ST_BOOT_HI:`FSP_ST_BOOT_LO] =
         fuse_r[`FSP_FUSE_BOOT_HI:`FSP_FUSE_BOOT_LO];
   end

   // one read outstanding; arready drops while an answer waits
   always_comb
   begin
      arready = !rvalid_r;
      rvalid = rvalid_r;
      rdata = rdata_r;
      rresp = rresp_r;
   end

   // read answer one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h00000000;
         rresp_r <= `FSP_RESP_OKAY;
      end
      else if (ce)
      begin
         if (arvalid && arready)
         begin
            rvalid_r <= 1'b1;
            rresp_r <= `FSP_RESP_OKAY;
            case (araddr)
               `FSP_OFS_FUSE: rdata_r <= fuse_r;
               `FSP_OFS_FUSE_WR: rdata_r <= 32'h00000000;
               `FSP_OFS_FLASH_CMD: rdata_r <= {16'h0000, cmd_r};
               `FSP_OFS_STATUS: rdata_r <= status_c;
               default:
               begin
                  rdata_r <= 32'h00000000;
                  rresp_r <= `FSP_RESP_SLVERR;
               end
            endcase
         end
         else if (rready)
         begin
            rvalid_r <= 1'b0;
         end
      end
   end

   // a refused command still completes with OKAY; the flag tells
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bresp_r <= `FSP_RESP_OKAY;
      end
      else if (ce && do_write)
      begin
         case (wa_c)
            `FSP_OFS_FUSE_WR, `FSP_OFS_FLASH_CMD, `FSP_OFS_STATUS:
               bresp_r <= `FSP_RESP_OKAY;
            default: bresp_r <= `FSP_RESP_SLVERR;
         endcase
      end
   end

endmodule

// >>> fsp_properties.sv
`timescale 1ns/1ns

// ****************
// port checks on the fuse guard
// ****************
module fsp_checker
   import fsp_pkg::*;
#(
   parameter bit HAS_EXT_MEM_IF = 1'b1,
   parameter logic [31:0] EXT_MEM_BASE = 32'hD0000000,
   parameter logic [31:0] EXT_MEM_LIMIT = 32'hDFFFFFFF
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic security_bit,
   input wire logic ext_chip_erase,
   input wire logic [31:0] fetch_addr,
   input wire logic fetch_privileged,
   input wire logic fetch_allow,
   input wire logic external_fetch_block_fuse,
   input wire logic secure_state_enable,
   input wire logic secure_state_debug_enable,
   input wire logic user_window_enable,
   input wire logic flash_op_start,
   input wire logic [1:0] flash_op_code,
   input wire logic cmd_rejected
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // fetch in external window
   wire in_win = fetch_addr >= EXT_MEM_BASE && fetch_addr <= EXT_MEM_LIMIT;
   // fuse write, both halves on one edge, byte 2 on
   wire fuse_wr = awvalid && awready && wvalid && wready && ce
      && awaddr == 8'h04 && wstrb[2];

   // erase request, then one running cycle for the decode flop
   sequence s_erase;
      ext_chip_erase && ce;
   endsequence
   sequence s_settled;
      s_erase ##1 ce;
   endsequence

   a_fetch_block: assert property (
      HAS_EXT_MEM_IF && fetch_privileged && in_win
      && !external_fetch_block_fuse |-> !fetch_allow)
      else $error("privileged external fetch let through");
   a_fetch_open: assert property (
      external_fetch_block_fuse || !HAS_EXT_MEM_IF || !in_win
      || !fetch_privileged |-> fetch_allow)
      else $error("allowed fetch was blocked");
   a_fuse_frozen: assert property (
      security_bit && !ext_chip_erase |=> $stable(external_fetch_block_fuse)
      && $stable(user_window_enable))
      else $error("protected fuse moved under security");
   a_erase_clears: assert property (
      s_erase |=> external_fetch_block_fuse && !user_window_enable)
      else $error("chip erase left fuses programmed");
   a_secure_idle: assert property (
      s_settled |=> !secure_state_enable && !secure_state_debug_enable)
      else $error("erased secure field not decoded as off");
   a_debug_needs: assert property (
      secure_state_debug_enable |-> secure_state_enable)
      else $error("secure debug without secure state");
   a_reject_set: assert property (
      fuse_wr && security_bit && !ext_chip_erase
      && wdata[16] != external_fetch_block_fuse |=> cmd_rejected)
      else $error("guarded fuse write not flagged");
   a_op_legal: assert property (
      flash_op_start |-> flash_op_code == 2'h1 || flash_op_code == 2'h2)
      else $error("illegal page operation handed on");
endmodule

bind fsp_top fsp_checker #(
   .HAS_EXT_MEM_IF(HAS_EXT_MEM_IF),
   .EXT_MEM_BASE(EXT_MEM_BASE),
   .EXT_MEM_LIMIT(EXT_MEM_LIMIT)
) u_chk (.*);

// >>> fsp_flash_model.sv
`timescale 1ns/1ns

// ****************
// flash controller stand-in
// ****************
module fsp_flash_model
(
   input wire logic aclk,
   input wire logic flash_op_start,
   input wire logic [1:0] flash_op_code,
   input wire logic [7:0] flash_op_page,
   output int op_cnt,
   output logic [9:0] last_op
);
   initial
   begin
      op_cnt = 0;
      last_op = 10'h000;
   end
   // only a start pulse is an order; code and page ride with it
   always @(posedge aclk)
      if (flash_op_start)
      begin
         op_cnt <= op_cnt + 1;
         last_op <= {flash_op_code, flash_op_page};
      end
endmodule

// >>> fuse_security_protection_tb.sv
`timescale 1ns/1ns

// ****************
// bench for the fuse guard
// ****************
module fuse_security_protection_tb;
   logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
   logic security_bit, ext_chip_erase, fetch_privileged;
   logic [7:0] awaddr, araddr, flash_op_page;
   logic [2:0] awprot, arprot;
   logic [31:0] wdata, fetch_addr, rdata, fz, d;
   logic [3:0] wstrb;
   logic awready, wready, bvalid, arready, rvalid, fetch_allow;
   logic external_fetch_block_fuse, secure_state_enable;
   logic secure_state_debug_enable, user_window_enable;
   logic flash_op_start, cmd_rejected;
   logic [1:0] bresp, rresp, flash_op_code, r;
   logic [9:0] last_op;
   int op_cnt, p, cyc = 0, error_cnt = 0, compares = 0;

   fsp_top dut (.*);
   fsp_flash_model u_flash (.*);

   // 50 MHz
   always #10 aclk = ~aclk;

   // ****************
   // checking and closing
   // ****************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_sim;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // hang guard
   always @(posedge aclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         error_cnt++;
         end_sim;
      end
   end

   // ****************
   // bus tasks, sampled at the falling edge
   // ****************
   task automatic wr(input logic [7:0] a, input logic [31:0] v,
      output logic [1:0] rs);
      logic ta, tw, tb = 1'b0;
      @(posedge aclk);
      {awaddr, wdata} <= {a, v};
      {awvalid, wvalid, bready} <= 3'h7;
      while (!tb)
      begin
         @(negedge aclk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         rs = bresp;
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v,
      output logic [1:0] rs);
      logic tr, tv = 1'b0;
      @(posedge aclk);
      {araddr, arvalid, rready} <= {a, 2'h3};
      while (!tv)
      begin
         @(negedge aclk);
         tr = arvalid && arready;
         tv = rvalid;
         v = rdata;
         rs = rresp;
         @(posedge aclk);
         if (tr) arvalid <= 1'b0;
      end
      rready <= 1'b0;
   endtask

   // read reject flag, then clear it
   task automatic rej(input logic e);
      rd(8'h0C, d, r);
      chk(32'(d[0]), 32'(e));
      wr(8'h0C, 32'h1, r);
   endtask

   // fuse word write and readback
   task automatic fw(input logic [31:0] v, input logic acc);
      wr(8'h04, v, r);
      chk(32'(r), 32'h0);
      if (acc) fz = v;
      rd(8'h00, d, r);
      chk(d, fz);
      rej(!acc);
   endtask

   task automatic cmd(input logic [1:0] op, input logic [7:0] pg,
      input logic acc);
      int n;
      n = op_cnt;
      wr(8'h08, {16'h0, pg, 6'h0, op}, r);
      rej(!acc);
      chk(32'(op_cnt), 32'(n + acc));
      if (acc) chk(32'(last_op), {22'h0, op, pg});
   endtask

   task automatic ft(input logic [31:0] a, input logic pv, input logic e);
      @(posedge aclk);
      fetch_addr <= a;
      fetch_privileged <= pv;
      @(negedge aclk);
      chk(32'(fetch_allow), 32'(e));
   endtask

   // {sse, secure_state_debug_enable, user window, fetch fuse}
   task automatic pins(input logic [3:0] e);
      chk(32'({secure_state_enable, secure_state_debug_enable,
         user_window_enable, external_fetch_block_fuse}), 32'(e));
   endtask

   // ****************
   // main sequence
   // ****************
   initial
   begin
      aclk = 1'b0;
      ce = 1'b1;
      wstrb = 4'hF;
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {security_bit, ext_chip_erase, fetch_privileged} = '0;
      {awaddr, araddr, awprot, arprot, wdata, fetch_addr} = '0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      fz = 32'hFFFFFFFF;
      rd(8'h00, d, r);
      chk(d, fz);
      pins(4'b0001);
      // window edges
      ft(32'hD0000000, 1'b1, 1'b1);
      fw(32'hFFFEFFFF, 1'b1);
      ft(32'hD0000000, 1'b1, 1'b0);
      ft(32'hDFFFFFFF, 1'b1, 1'b0);
      ft(32'hCFFFFFFF, 1'b1, 1'b1);
      ft(32'hE0000000, 1'b1, 1'b1);
      ft(32'hD0000000, 1'b0, 1'b1);
      fw(32'hFFFFFFFF, 1'b1);
      ft(32'hD0000000, 1'b1, 1'b1);
      for (int v = 0; v < 4; v++)
      begin
         fw({fz[31:22], 2'(v), fz[19:0]}, 1'b1);
         pins({v != 3, v == 2, 2'b01});
      end
      fw(32'hFFBFFFFF, 1'b1);
      pins(4'b0011);
      // each boot size: last guarded, first free page
      for (int s = 0; s < 8; s++)
      begin
         p = (s == 7) ? 0 : 1 << (7 - s);
         fw({fz[31:20], 3'(s), fz[16:0]}, 1'b1);
         if (p > 0) cmd(2'(1 + s % 2), 8'(p - 1), 1'b0);
         cmd(2'(1 + s % 2), 8'(p), 1'b1);
      end
      cmd(2'h3, 8'hFF, 1'b0);
      cmd(2'h0, 8'hFF, 1'b0);
      // security set: guarded bits frozen
      fw(32'hFFB6FFFF, 1'b1);
      security_bit <= 1'b1;
      fw(32'hFFF6FFFF, 1'b0);
      fw(32'hFFB7FFFF, 1'b0);
      fw(32'hFFBEFFFF, 1'b0);
      fw(32'hFFB60000, 1'b1);
      cmd(2'h1, 8'h0F, 1'b0);
      cmd(2'h2, 8'h10, 1'b1);
      pins(4'b0010);
      @(posedge aclk);
      ext_chip_erase <= 1'b1;
      @(posedge aclk);
      ext_chip_erase <= 1'b0;
      fz = 32'hFFFFFFFF;
      rd(8'h00, d, r);
      chk(d, fz);
      pins(4'b0001);
      cmd(2'h1, 8'h00, 1'b1);
      // unmapped read, write to read-only word
      rd(8'h10, d, r);
      chk(d, 32'h0);
      chk(32'(r), 32'h2);
      wr(8'h00, 32'h0, r);
      chk(32'(r), 32'h2);
      rd(8'h00, d, r);
      chk(d, fz);
      end_sim;
   end
endmodule
